/* File: sdram_ctl_cfg.svh */
// Offsets, field positions, reset values and codes of the SDRAM control
// and configuration block. Included by the design.
`ifndef SDRAM_CTL_CFG_SVH
`define SDRAM_CTL_CFG_SVH
// ***********************************************************************
// Register byte offsets
// ***********************************************************************
`define OFS_MANUAL_COMMAND 8'h04
`define OFS_REFRESH_CONTROL 8'h08
`define OFS_DEVICE0_SIZE_MAP 8'h10
`define OFS_DEVICE1_SIZE_MAP 8'h14
`define OFS_MEMORY_MODE_LOAD 8'h18
`define OFS_MEMORY_EXT_MODE_LOAD 8'h1c
// ***********************************************************************
// Field positions
// ***********************************************************************
`define CMD_AUTO_WAKE 5
`define CMD_SELF_REF 4
`define CMD_MANUAL_REF 3
`define CMD_PRECHARGE 2
`define CMD_CKE_FORCE 1
`define CMD_INIT 0
`define REF_EN_BIT 15
`define REF_INTERVAL_MSB 14
`define MAP_BASE_MSB 28
`define MAP_BASE_LSB 21
`define BUS_WIDTH_BIT 3
`define SIZE_CODE_MSB 2
`define MODE_CFG_MSB 13
`define MODE_BURST_ORDER 3
`define EXT_DRIVE_BIT 1
`define EXT_DLL_BIT 0
// ***********************************************************************
// Reset values and constants
// ***********************************************************************
`define RST_MANUAL_COMMAND 32'h0000_0021
`define RST_REFRESH_CONTROL 32'h0000_80ff
`define RST_DEVICE1_SIZE_MAP 32'h1000_0000
`define RST_MEMORY_MODE_LOAD 32'h0000_0032
`define RST_MEMORY_EXT_MODE_LOAD 32'h0000_4000
`define SIZE_CODE_2MB 3'h1
`define SIZE_CODE_16MB 3'h4
`define KIND_SDR 2'h0
`define KIND_LPDDR 2'h1
`define KIND_DDR 2'h2
`define KIND_DDR2 2'h3
`define CAS_CODE_2 3'h2
`define CAS_CODE_3 3'h3
`define CAS_CODE_4 3'h4
`define BURST_LEN_CODE 3'h2
`define SHADOW_TOP 3'h4
`define LOW_TOP 3'h0
`endif

/* File: sdram_ctl_pkg.sv */
// Types shared by the SDRAM control and configuration block.
// Assumes sdram_ctl_cfg.svh is on the include path.
package sdram_ctl_pkg;
  // Command word driven toward the memory pins, chip selects active low.
  typedef struct packed {
    logic [1:0] cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bank;
    logic [13:0] addr;
  } mem_cmd_t;
  // One-hot sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SELF = 3'b010,
    ST_BUSY = 3'b100
  } seq_state_t;
  // Maintenance operation in flight.
  typedef enum logic [2:0] {
    OP_REF = 3'b001,
    OP_PRE = 3'b010,
    OP_LMR = 3'b100
  } seq_op_t;
endpackage

/* File: sdram_command_refresh_config.sv */
// SDRAM controller command, refresh and configuration registers, with a
// small maintenance sequencer that drives memory commands and clock enable.
// Assumes a classic Wishbone master, a one-cycle crystal tick synchronous
// to clk_i, and a data path outside that holds its request until granted.
//
// Overview of operation
// - With auto wake set, an interrupt in self-refresh exits it, clearing the bit.
// - Self-refresh bit enters self-refresh; no access or refresh served meanwhile.
// - Manual refresh bit issues one auto-refresh, cleared by hardware when done.
// - Precharge bit issues precharge-all, cleared by hardware when done.
// - Clock enable follows the sequencer, or stays high when forced.
// - Init bit resets to one and blocks all system reads and writes.
// - Periodic refresh, when enabled, fires each time counter hits interval.
// - Fifteen-bit interval counted in crystal clock cycles.
// - Base field places device address zero at base times 2 megabytes.
// - Low region also answers at the shadow window from 0x8000_0000.
// - Bus width bit reads zero; it is reserved in device one register.
// - Size code 000 disables, 001 to 111 select 2 to 128 megabytes.
// - Device zero size resets to 16 MB for DDR or DDR2, else 2 MB.
// - Writing the mode register sends a load mode command with its value.
// - Mode loads go to both devices at once.
// - Writing the extended mode register sends a load mode command too.
// - CAS latency code is used for read timing; legal codes depend on type.
// - Burst order bit is held at zero.
// - Burst length code must be 010 for bursts of four.
// - Extended bit 0 disables DLL when one; bit 1 selects reduced drive.
// - Upper mode bits pass unchanged into the load mode command.
// - Memory kind encodes SDR, LPDDR, DDR, DDR2 and comes from power-on.
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ns
`include "sdram_ctl_cfg.svh"
module sdram_command_refresh_config #(
  parameter int CMD_WAIT = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // System side
  input wire logic sys_irq_i,
  input wire logic xtal_tick_i,
  input wire logic [1:0] poc_kind_i,
  input wire logic sys_req_i,
  input wire logic [31:0] sys_addr_i,
  output logic sys_gnt_o,
  output logic [1:0] sys_hit_o,
  // Memory side
  output sdram_ctl_pkg::mem_cmd_t mem_cmd_o,
  output logic cke_o,
  output logic [1:0] memory_kind_o,
  output logic [2:0] cas_latency_o,
  output logic cas_code_ok_o,
  output logic dll_off_o,
  output logic reduced_drive_sel_o
);
  localparam int WAIT_MAX = 12;
  localparam logic [7:0] WAIT_LOAD = 8'(CMD_WAIT - 1);
  localparam logic [31:0] EMR_FIXED = `RST_MEMORY_EXT_MODE_LOAD;

  // *********************************************************************
  // Wishbone slave
  // *********************************************************************
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic wr_cmd, wr_ref, wr_sz0, wr_sz1, wr_mr, wr_emr;
  logic [31:0] manual_command_reg, manual_command_next;
  logic [31:0] refresh_control_reg, refresh_control_next;
  logic [31:0] device0_size_map_reg, device0_size_map_next;
  logic [31:0] device1_size_map_reg, device1_size_map_next;
  logic [31:0] memory_mode_load_reg, memory_mode_load_next;
  logic [31:0] memory_ext_mode_load_reg, memory_ext_mode_load_next;
  logic [1:0] memory_kind_reg, memory_kind_next;
  logic wr_go;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Writes land on the edge that carries the acknowledge, as the master
  // sees it, so a write and its ack can never be split by a stall.
  assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
  assign wr_cmd = wr_go & (wb_adr_i == `OFS_MANUAL_COMMAND);
  assign wr_ref = wr_go & (wb_adr_i == `OFS_REFRESH_CONTROL);
  assign wr_sz0 = wr_go & (wb_adr_i == `OFS_DEVICE0_SIZE_MAP);
  assign wr_sz1 = wr_go & (wb_adr_i == `OFS_DEVICE1_SIZE_MAP);
  assign wr_mr = wr_go & (wb_adr_i == `OFS_MEMORY_MODE_LOAD);
  assign wr_emr = wr_go & (wb_adr_i == `OFS_MEMORY_EXT_MODE_LOAD);

  // Unmapped addresses are acknowledged and read as zero.
  always_comb begin
    ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
    rdat_next = 32'h0000_0000;
    unique case (wb_adr_i)
      `OFS_MANUAL_COMMAND: rdat_next = manual_command_reg;
      `OFS_REFRESH_CONTROL: rdat_next = refresh_control_reg;
      `OFS_DEVICE0_SIZE_MAP: rdat_next = device0_size_map_reg;
      `OFS_DEVICE1_SIZE_MAP: rdat_next = device1_size_map_reg;
      `OFS_MEMORY_MODE_LOAD: rdat_next = memory_mode_load_reg;
      `OFS_MEMORY_EXT_MODE_LOAD: rdat_next = memory_ext_mode_load_reg;
      default: rdat_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // *********************************************************************
  // Sequencer and refresh counter signals
  // *********************************************************************
  sdram_ctl_pkg::seq_state_t state_reg, state_next;
  sdram_ctl_pkg::seq_op_t op_reg, op_next;
  sdram_ctl_pkg::mem_cmd_t cmd_reg, cmd_next;
  logic [7:0] wait_reg, wait_next;
  logic [14:0] rcnt_reg, rcnt_next;
  logic per_pend_reg, per_pend_next;
  logic lmr_mr_reg, lmr_mr_next, lmr_emr_reg, lmr_emr_next;
  logic done_ref, done_pre, done_per, done_mr, done_emr;
  logic wait_done;

  assign wait_done = (state_reg == sdram_ctl_pkg::ST_BUSY) &&
                     (wait_reg == 8'h00);

  // *********************************************************************
  // Register file
  // *********************************************************************
  always_comb begin
    manual_command_next = manual_command_reg;
    if (wr_cmd) begin
      manual_command_next = merge(manual_command_reg, wb_dat_i, wb_sel_i);
    end
    // Hardware clears lose to a software set in the same cycle.
    if (manual_command_reg[`CMD_SELF_REF] &&
        manual_command_reg[`CMD_AUTO_WAKE] && sys_irq_i &&
        !(wr_cmd && wb_dat_i[`CMD_SELF_REF] && wb_sel_i[0])) begin
      manual_command_next[`CMD_SELF_REF] = 1'b0;
    end
    if (done_ref &&
        !(wr_cmd && wb_dat_i[`CMD_MANUAL_REF] && wb_sel_i[0])) begin
      manual_command_next[`CMD_MANUAL_REF] = 1'b0;
    end
    if (done_pre && !(wr_cmd && wb_dat_i[`CMD_PRECHARGE] && wb_sel_i[0])) begin
      manual_command_next[`CMD_PRECHARGE] = 1'b0;
    end
    manual_command_next[31:6] = '0;

    refresh_control_next = refresh_control_reg;
    if (wr_ref) begin
      refresh_control_next = merge(refresh_control_reg, wb_dat_i, wb_sel_i);
    end
    refresh_control_next[31:16] = '0;

    device0_size_map_next = device0_size_map_reg;
    if (wr_sz0) begin
      device0_size_map_next = merge(device0_size_map_reg, wb_dat_i, wb_sel_i);
    end
    device0_size_map_next[31:29] = '0;
    device0_size_map_next[20:3] = '0;

    device1_size_map_next = device1_size_map_reg;
    if (wr_sz1) begin
      device1_size_map_next = merge(device1_size_map_reg, wb_dat_i, wb_sel_i);
    end
    device1_size_map_next[31:29] = '0;
    device1_size_map_next[20:0] = '0;

    memory_mode_load_next = memory_mode_load_reg;
    if (wr_mr) begin
      memory_mode_load_next = merge(memory_mode_load_reg, wb_dat_i, wb_sel_i);
    end
    memory_mode_load_next[31:14] = '0;
    memory_mode_load_next[`MODE_BURST_ORDER] = 1'b0;
    memory_mode_load_next[2:0] = `BURST_LEN_CODE;

    memory_ext_mode_load_next = memory_ext_mode_load_reg;
    if (wr_emr) begin
      memory_ext_mode_load_next = merge(memory_ext_mode_load_reg, wb_dat_i,
                                        wb_sel_i);
    end
    // The bits above the configuration field keep their reset pattern.
    memory_ext_mode_load_next[31:14] = EMR_FIXED[31:14];
    memory_kind_next = memory_kind_reg;
  end

  // The power-on strap is caught while reset is held, as the reset is
  // synchronous and the strap is stable by then.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      manual_command_reg <= `RST_MANUAL_COMMAND;
      refresh_control_reg <= `RST_REFRESH_CONTROL;
      memory_kind_reg <= poc_kind_i;
      if (poc_kind_i == `KIND_DDR || poc_kind_i == `KIND_DDR2) begin
        device0_size_map_reg <= {29'h0, `SIZE_CODE_16MB};
      end else begin
        device0_size_map_reg <= {29'h0, `SIZE_CODE_2MB};
      end
      device1_size_map_reg <= `RST_DEVICE1_SIZE_MAP;
      memory_mode_load_reg <= `RST_MEMORY_MODE_LOAD;
      memory_ext_mode_load_reg <= `RST_MEMORY_EXT_MODE_LOAD;
    end else begin
      manual_command_reg <= manual_command_next;
      refresh_control_reg <= refresh_control_next;
      memory_kind_reg <= memory_kind_next;
      device0_size_map_reg <= device0_size_map_next;
      device1_size_map_reg <= device1_size_map_next;
      memory_mode_load_reg <= memory_mode_load_next;
      memory_ext_mode_load_reg <= memory_ext_mode_load_next;
    end
  end

  // *********************************************************************
  // Address map decode
  // *********************************************************************
  logic [2:0] size_code;
  logic [28:0] low_addr;
  logic in_region;

  // Device one has no size field of its own and takes device zero's size.
  assign size_code = device0_size_map_reg[`SIZE_CODE_MSB:0];
  assign low_addr = sys_addr_i[28:0];
  assign in_region = (sys_addr_i[31:29] == `LOW_TOP) ||
                     (sys_addr_i[31:29] == `SHADOW_TOP);

  function automatic logic dev_hit(input logic [7:0] base,
                                   input logic [7:0] blk,
                                   input logic [2:0] code);
    logic [7:0] ofs;
    logic [8:0] span;
    ofs = blk - base;
    span = 9'(9'h001 << (code - 3'h1));
    return (code != 3'h0) && (blk >= base) && ({1'b0, ofs} < span);
  endfunction

  always_comb begin
    sys_hit_o[0] = in_region &&
      dev_hit(device0_size_map_reg[`MAP_BASE_MSB:`MAP_BASE_LSB],
              low_addr[`MAP_BASE_MSB:`MAP_BASE_LSB], size_code);
    sys_hit_o[1] = in_region &&
      dev_hit(device1_size_map_reg[`MAP_BASE_MSB:`MAP_BASE_LSB],
              low_addr[`MAP_BASE_MSB:`MAP_BASE_LSB], size_code);
  end

  // *********************************************************************
  // Refresh period counter, one step per crystal tick
  // *********************************************************************
  always_comb begin
    rcnt_next = rcnt_reg;
    per_pend_next = per_pend_reg & ~done_per;
    if (!refresh_control_reg[`REF_EN_BIT]) begin
      rcnt_next = 15'h0000;
    end else if (xtal_tick_i) begin
      rcnt_next = rcnt_reg + 15'h0001;
      if (rcnt_next == refresh_control_reg[`REF_INTERVAL_MSB:0]) begin
        rcnt_next = 15'h0000;
        per_pend_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rcnt_reg <= 15'h0000;
      per_pend_reg <= 1'b0;
    end else begin
      rcnt_reg <= rcnt_next;
      per_pend_reg <= per_pend_next;
    end
  end

  // *********************************************************************
  // Maintenance sequencer
  // *********************************************************************
  logic self_bit, maint_busy;
  assign self_bit = manual_command_reg[`CMD_SELF_REF];
  assign done_ref = wait_done && op_reg == sdram_ctl_pkg::OP_REF &&
                    !per_pend_reg;
  assign done_per = wait_done && op_reg == sdram_ctl_pkg::OP_REF &&
                    per_pend_reg;
  assign done_pre = wait_done && op_reg == sdram_ctl_pkg::OP_PRE;
  assign done_mr = wait_done && op_reg == sdram_ctl_pkg::OP_LMR && lmr_mr_reg;
  assign done_emr = wait_done && op_reg == sdram_ctl_pkg::OP_LMR &&
                    !lmr_mr_reg;
  assign maint_busy = manual_command_reg[`CMD_MANUAL_REF] |
                      manual_command_reg[`CMD_PRECHARGE] |
                      per_pend_reg | lmr_mr_reg | lmr_emr_reg;

  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    wait_next = (wait_reg != 8'h00) ? wait_reg - 8'h01 : 8'h00;
    cmd_next = '{cs_n: 2'b11, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                 bank: 2'b00, addr: 14'h0000};
    lmr_mr_next = (lmr_mr_reg & ~done_mr) | wr_mr;
    lmr_emr_next = (lmr_emr_reg & ~done_emr) | wr_emr;
    unique case (state_reg)
      sdram_ctl_pkg::ST_IDLE: begin
        if (self_bit) begin
          // Refresh with clock enable low enters self-refresh.
          state_next = sdram_ctl_pkg::ST_SELF;
          cmd_next.cs_n = 2'b00;
          cmd_next.ras_n = 1'b0;
          cmd_next.cas_n = 1'b0;
        end else if (manual_command_reg[`CMD_PRECHARGE]) begin
          state_next = sdram_ctl_pkg::ST_BUSY;
          op_next = sdram_ctl_pkg::OP_PRE;
          wait_next = WAIT_LOAD;
          cmd_next.cs_n = 2'b00;
          cmd_next.ras_n = 1'b0;
          cmd_next.we_n = 1'b0;
          cmd_next.addr[10] = 1'b1;
        end else if (manual_command_reg[`CMD_MANUAL_REF] || per_pend_reg) begin
          state_next = sdram_ctl_pkg::ST_BUSY;
          op_next = sdram_ctl_pkg::OP_REF;
          wait_next = WAIT_LOAD;
          cmd_next.cs_n = 2'b00;
          cmd_next.ras_n = 1'b0;
          cmd_next.cas_n = 1'b0;
        end else if (lmr_mr_reg || lmr_emr_reg) begin
          state_next = sdram_ctl_pkg::ST_BUSY;
          op_next = sdram_ctl_pkg::OP_LMR;
          wait_next = WAIT_LOAD;
          cmd_next.cs_n = 2'b00;
          cmd_next.ras_n = 1'b0;
          cmd_next.cas_n = 1'b0;
          cmd_next.we_n = 1'b0;
          cmd_next.bank = lmr_mr_reg ? 2'b00 : 2'b01;
          cmd_next.addr = lmr_mr_reg ?
            memory_mode_load_reg[`MODE_CFG_MSB:0] :
            memory_ext_mode_load_reg[`MODE_CFG_MSB:0];
        end
      end
      sdram_ctl_pkg::ST_SELF: begin
        if (!self_bit) begin
          state_next = sdram_ctl_pkg::ST_BUSY;
          op_next = sdram_ctl_pkg::OP_PRE;
          wait_next = WAIT_LOAD;
        end
      end
      sdram_ctl_pkg::ST_BUSY: begin
        if (wait_reg == 8'h00) begin
          state_next = sdram_ctl_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= sdram_ctl_pkg::ST_IDLE;
      op_reg <= sdram_ctl_pkg::OP_REF;
      wait_reg <= 8'h00;
      cmd_reg <= '{cs_n: 2'b11, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                   bank: 2'b00, addr: 14'h0000};
      lmr_mr_reg <= 1'b0;
      lmr_emr_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      wait_reg <= wait_next;
      cmd_reg <= cmd_next;
      lmr_mr_reg <= lmr_mr_next;
      lmr_emr_reg <= lmr_emr_next;
    end
  end

  // *********************************************************************
  // Outputs
  // *********************************************************************
  // A stalled requester keeps its request up; grant comes once unblocked.
  assign sys_gnt_o = sys_req_i && state_reg == sdram_ctl_pkg::ST_IDLE &&
                     !self_bit && !manual_command_reg[`CMD_INIT] &&
                     !maint_busy;
  assign cke_o = manual_command_reg[`CMD_CKE_FORCE] ||
                 state_reg != sdram_ctl_pkg::ST_SELF;
  assign mem_cmd_o = cmd_reg;
  assign memory_kind_o = memory_kind_reg;
  assign cas_latency_o = memory_mode_load_reg[6:4];
  assign dll_off_o = memory_ext_mode_load_reg[`EXT_DLL_BIT];
  assign reduced_drive_sel_o = memory_ext_mode_load_reg[`EXT_DRIVE_BIT];

  always_comb begin
    unique case (memory_kind_reg)
      `KIND_SDR: cas_code_ok_o = cas_latency_o >= `CAS_CODE_2 &&
                                 cas_latency_o <= `CAS_CODE_4;
      `KIND_DDR: cas_code_ok_o = cas_latency_o == `CAS_CODE_2 ||
                                 cas_latency_o == `CAS_CODE_3;
      `KIND_DDR2: cas_code_ok_o = cas_latency_o == `CAS_CODE_3 ||
                                  cas_latency_o == `CAS_CODE_4;
      default: cas_code_ok_o = cas_latency_o == `CAS_CODE_2 ||
                               cas_latency_o == `CAS_CODE_3;
    endcase
  end

  // *********************************************************************
  // Assertions
  // *********************************************************************
  property p_wake;
    @(posedge clk_i) disable iff (rst_i)
    self_bit && manual_command_reg[`CMD_AUTO_WAKE] && sys_irq_i && !wr_cmd
    |=> !self_bit;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on irq");

  property p_self_block;
    @(posedge clk_i) disable iff (rst_i)
    state_reg == sdram_ctl_pkg::ST_SELF && self_bit |-> !sys_gnt_o &&
      state_next == sdram_ctl_pkg::ST_SELF &&
      (cmd_reg.ras_n || $past(state_reg) != sdram_ctl_pkg::ST_SELF);
  endproperty
  a_self_block: assert property (p_self_block)
    else $error("self busy");

  property p_ref_clear;
    @(posedge clk_i) disable iff (rst_i)
    state_reg == sdram_ctl_pkg::ST_IDLE && !self_bit &&
    !manual_command_reg[`CMD_PRECHARGE] && manual_command_reg[`CMD_MANUAL_REF]
    && !per_pend_reg |=> !cmd_reg.ras_n && !cmd_reg.cas_n && cmd_reg.we_n
    ##[1:WAIT_MAX] !manual_command_reg[`CMD_MANUAL_REF];
  endproperty
  a_ref_clear: assert property (p_ref_clear)
    else $error("ref stuck");

  property p_pre_clear;
    @(posedge clk_i) disable iff (rst_i)
    state_reg == sdram_ctl_pkg::ST_IDLE && !self_bit &&
    manual_command_reg[`CMD_PRECHARGE] |=> !cmd_reg.we_n &&
    cmd_reg.addr[10] ##[1:WAIT_MAX] !manual_command_reg[`CMD_PRECHARGE];
  endproperty
  a_pre_clear: assert property (p_pre_clear)
    else $error("pre stuck");

  property p_cke;
    @(posedge clk_i) disable iff (rst_i)
    !cke_o |-> state_reg == sdram_ctl_pkg::ST_SELF &&
      !manual_command_reg[`CMD_CKE_FORCE];
  endproperty
  a_cke: assert property (p_cke) else $error("cke low wrongly");

  property p_init_block;
    @(posedge clk_i) disable iff (rst_i)
    manual_command_reg[`CMD_INIT] |-> !sys_gnt_o;
  endproperty
  a_init_block: assert property (p_init_block)
    else $error("init grant");

  property p_ref_off;
    @(posedge clk_i) disable iff (rst_i)
    !refresh_control_reg[`REF_EN_BIT] |=> !$rose(per_pend_reg);
  endproperty
  a_ref_off: assert property (p_ref_off)
    else $error("refresh while off");

  property p_lmr_both;
    @(posedge clk_i) disable iff (rst_i)
    !cmd_reg.ras_n && !cmd_reg.cas_n && !cmd_reg.we_n |->
      cmd_reg.cs_n == 2'b00 && $past(lmr_mr_reg || lmr_emr_reg);
  endproperty
  a_lmr_both: assert property (p_lmr_both)
    else $error("lmr one chip");

  property p_burst;
    @(posedge clk_i) disable iff (rst_i)
    wr_mr |=> !memory_mode_load_reg[`MODE_BURST_ORDER] && lmr_mr_reg;
  endproperty
  a_burst: assert property (p_burst)
    else $error("burst order set");
endmodule

/* File: sdram_dev_model.sv */
// Memory device model: counts refresh and precharge-all commands and keeps
// the last mode load. Assumes the packed command word of the controller.
`timescale 1ns/1ns
module sdram_dev_model (
  input wire logic clk_i,
  input wire sdram_ctl_pkg::mem_cmd_t cmd_i,
  output int refs_o,
  output int pres_o,
  output logic [15:0] lmr_o
);
  always @(posedge clk_i) begin
    // Both chip selects low, so one command reaches both devices.
    if (cmd_i.cs_n == 2'b00 && !cmd_i.ras_n) begin
      if (!cmd_i.cas_n && cmd_i.we_n)
        refs_o <= refs_o + 1;
      if (cmd_i.cas_n && !cmd_i.we_n && cmd_i.addr[10])
        pres_o <= pres_o + 1;
      if (!cmd_i.cas_n && !cmd_i.we_n)
        lmr_o <= {cmd_i.bank, cmd_i.addr};
    end
  end
endmodule

/* File: test_sdram_command_refresh_config.sv */
// Self-checking bench for the SDRAM command and configuration block.
// Assumes the package, header and device model are compiled first.
`timescale 1ns/1ns
module test_sdram_command_refresh_config;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sys_irq_i;
  logic xtal_tick_i, sys_req_i, sys_gnt_o, cke_o, cas_code_ok_o;
  logic dll_off_o, reduced_drive_sel_o;
  logic [1:0] poc_kind_i, sys_hit_o, memory_kind_o;
  logic [2:0] cas_latency_o;
  logic [3:0] wb_sel_i;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, sys_addr_i, q;
  logic [15:0] lmr;
  sdram_ctl_pkg::mem_cmd_t mem_cmd_o;
  int refs, pres, r0, bad_count, comparisons, cyc;
  sdram_command_refresh_config #(.CMD_WAIT(2)) DUT (.*);
  sdram_dev_model mem (.clk_i(clk_i), .cmd_i(mem_cmd_o), .refs_o(refs),
    .pres_o(pres), .lmr_o(lmr));
  initial begin
    clk_i = 0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      final_report;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(0, a, 0);
    chk(q, e);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      xtal_tick_i <= 1;
      @(posedge clk_i);
      xtal_tick_i <= 0;
      repeat (3) @(posedge clk_i);
    end
  endtask
  task automatic hit(input logic [31:0] a, input logic [1:0] e);
    sys_addr_i <= a;
    @(posedge clk_i);
    chk(sys_hit_o, e);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, sys_irq_i, xtal_tick_i, sys_req_i} <= '0;
    {wb_adr_i, wb_dat_i, sys_addr_i} <= '0;
    wb_sel_i <= 4'hf;
    poc_kind_i <= 2'h2;
    rst_i <= 1;
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rd(8'h04, 32'h0000_0021);
    rd(8'h08, 32'h0000_80ff);
    rd(8'h10, 32'h0000_0004);
    rd(8'h14, 32'h1000_0000);
    rd(8'h18, 32'h0000_0032);
    rd(8'h1c, 32'h0000_4000);
    rd(8'h40, 32'h0000_0000);
    chk(memory_kind_o, 2'h2);
    sys_req_i <= 1;
    wb(1, 8'h08, 32'h0000_0000);
    chk(sys_gnt_o, 1'h0);
    $display("reset values done");
    r0 = refs;
    wb(1, 8'h04, 32'h0000_0029);
    do wb(0, 8'h04, 0); while (q & 32'h0000_0008);
    chk(refs - r0, 1);
    wb(1, 8'h04, 32'h0000_0025);
    do wb(0, 8'h04, 0); while (q & 32'h0000_0004);
    chk(pres, 1);
    wb(1, 8'h18, 32'h0000_3f32);
    repeat (4) @(posedge clk_i);
    chk(lmr, 16'h3f32);
    chk({cas_latency_o, cas_code_ok_o}, 4'h7);
    wb(1, 8'h1c, 32'h0000_2003);
    repeat (8) @(posedge clk_i);
    chk(lmr, 16'h6003);
    chk({dll_off_o, reduced_drive_sel_o}, 2'h3);
    wb(1, 8'h18, 32'h0000_0042);
    chk(cas_code_ok_o, 1'h0);
    $display("commands done");
    wb(1, 8'h04, 32'h0000_0020);
    repeat (8) @(posedge clk_i);
    chk(sys_gnt_o, 1'h1);
    hit(32'h8000_0000, 2'h1);
    hit(32'h1000_0000, 2'h2);
    hit(32'h0100_0000, 2'h0);
    wb(1, 8'h10, 32'h0020_000f);
    rd(8'h10, 32'h0020_0007);
    hit(32'h0020_0000, 2'h1);
    hit(32'h0000_0000, 2'h0);
    wb(1, 8'h10, 32'h0020_0000);
    hit(32'h0020_0000, 2'h0);
    $display("decode done");
    wb(1, 8'h08, 32'h0000_8003);
    r0 = refs;
    ticks(20);
    chk(refs - r0, 6);
    wb(1, 8'h08, 32'h0000_0000);
    r0 = refs;
    ticks(8);
    chk(refs - r0, 0);
    $display("periodic done");
    wb(1, 8'h04, 32'h0000_0012);
    repeat (4) @(posedge clk_i);
    chk({cke_o, sys_gnt_o}, 2'h2);
    sys_irq_i <= 1;
    rd(8'h04, 32'h0000_0012);
    sys_irq_i <= 0;
    wb(1, 8'h04, 32'h0000_0030);
    repeat (4) @(posedge clk_i);
    chk({cke_o, sys_gnt_o}, 2'h0);
    sys_irq_i <= 1;
    @(posedge clk_i);
    rd(8'h04, 32'h0000_0020);
    sys_irq_i <= 0;
    repeat (8) @(posedge clk_i);
    chk({cke_o, sys_gnt_o}, 2'h3);
    $display("self refresh done");
    poc_kind_i <= 2'h0;
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rd(8'h10, 32'h0000_0001);
    chk({memory_kind_o, cas_code_ok_o}, 3'h1);
    $display("second reset done");
    final_report;
  end
endmodule
